// ==== vc_res_pkg.sv ====
// Constants for the virtual channel resource status and capability block
// How it works
// - Any software write to a VC0 arbitration table entry sets the coherency flag.
// - Coherency flag is valid only when the chosen scheme uses the table.
// - VC0 negotiation pending bit always reads zero.
// - Resource 1 scheme capability is eight bits; bit 0 resets one.
// - Several scheme capability bits may be set together.
// - Advanced packet switching capability bit reads zero, read-only.
// - Reject snoop capability bit reads zero, read-only.
// - Seven-bit max time slot field reads zero, read-only.
// - Table offset in 16-byte units from capability base, resets zero.
// - Writing one to load request starts a reload; zero ignored; reads zero.
package vc_res_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] VC0_RESOURCE_CONTROL_OFS = 12'h214;
   localparam logic [11:0] VC0_RESOURCE_STATUS_OFS = 12'h218;
   localparam logic [11:0] VC1_RESOURCE_CAPABILITY_OFS = 12'h21c;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int COHERENCY_BIT = 16;
   localparam int NEG_PENDING_BIT = 17;
   localparam int ARB_CAP_LSB = 0;
   localparam int ARB_CAP_W = 8;
   localparam int ADV_PS_BIT = 14;
   localparam int REJ_SNOOP_BIT = 15;
   localparam int MAX_TS_LSB = 16;
   localparam int MAX_TS_W = 7;
   localparam int TBL_OFS_LSB = 24;
   localparam int TBL_OFS_W = 8;
   // ----------------------------------------
   // Reset values, writable masks and load length
   // ----------------------------------------
   localparam logic [7:0] ARB_CAP_RESET = 8'h01;
   localparam logic [7:0] ARB_CAP_WMASK = 8'hc1;
   localparam logic [7:0] TBL_OFS_RESET = 8'h00;
   localparam logic [2:0] LOAD_CYCLES = 3'h4;
endpackage

// ==== arb_table_loader.sv ====
// Table load sequencer that copies the arbitration table into the arbiter
`timescale 1ns/1ps
module arb_table_loader
   import vc_res_pkg::*;
#(
   parameter logic [2:0] CYCLES = LOAD_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   output logic busy_o,
   output logic done_o
);
   logic [2:0] count_reg;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= 3'h0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (busy_o) begin
            if (count_reg == 3'h1) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            count_reg <= count_reg - 3'h1;
         end else if (start_i) begin
            busy_o <= 1'b1;
            count_reg <= CYCLES;
         end
      end
   end
endmodule

// ==== vc_resource_status_capability.sv ====
// Status of VC resource 0 and capability of VC resource 1
`timescale 1ns/1ps
module vc_resource_status_capability
   import vc_res_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic write_lock_i,
   input wire logic arb_table_wr_i,
   input wire logic [2:0] arb_scheme_select_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   output logic arb_table_coherency_flag_o,
   output logic table_in_use_o,
   output logic arb_load_busy_o,
   output logic [7:0] arb_scheme_capability_o,
   output logic [7:0] arb_table_offset_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic coherency_reg;
   logic load_pending_reg;
   logic load_req;
   logic load_done;
   logic [7:0] cap_reg;
   logic [7:0] ofs_reg;
   logic [31:0] status_word;
   logic [31:0] cap_word;
   logic cap_hit;

   assign cap_hit = cfg_wr_i && cfg_addr_i == VC1_RESOURCE_CAPABILITY_OFS;
   // Load request is write-one pulse; nothing stored, so reads give zero
   assign load_req = cfg_wr_i && cfg_addr_i == VC0_RESOURCE_CONTROL_OFS
      && cfg_be_i[2] && cfg_wdata_i[COHERENCY_BIT];

   arb_table_loader #(
      .CYCLES(LOAD_CYCLES)
   ) u_loader (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .start_i(load_req),
      .busy_o(arb_load_busy_o),
      .done_o(load_done)
   );

   // ----------------------------------------
   // Table coherency
   // ----------------------------------------
   // Table write wins over load completion in the same cycle; a write earlier in the load is cleared at completion
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         coherency_reg <= 1'b0;
         load_pending_reg <= 1'b0;
      end else begin
         if (arb_table_wr_i) begin
            coherency_reg <= 1'b1;
         end else if (load_done && load_pending_reg) begin
            coherency_reg <= 1'b0;
         end
         if (load_req) begin
            load_pending_reg <= 1'b1;
         end else if (load_done) begin
            load_pending_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Lockable capability fields
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cap_reg <= ARB_CAP_RESET;
         ofs_reg <= TBL_OFS_RESET;
      end else if (cap_hit && !write_lock_i) begin
         if (cfg_be_i[0]) begin
            // Bit 0 kept set; bits 6 and 7 may be set in any mix, bits 1 to 5 stay clear
            cap_reg <= (cfg_wdata_i[7:0] & ARB_CAP_WMASK)
               | ARB_CAP_RESET;
         end
         if (cfg_be_i[3]) begin
            ofs_reg <= cfg_wdata_i[31:24];
         end
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      status_word = 32'h0;
      status_word[COHERENCY_BIT] = coherency_reg;
      status_word[NEG_PENDING_BIT] = 1'b0;
      cap_word = 32'h0;
      cap_word[ARB_CAP_W-1:ARB_CAP_LSB] = cap_reg;
      cap_word[ADV_PS_BIT] = 1'b0;
      cap_word[REJ_SNOOP_BIT] = 1'b0;
      cap_word[MAX_TS_LSB+:MAX_TS_W] = 7'h00;
      cap_word[TBL_OFS_LSB+:TBL_OFS_W] = ofs_reg;
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_rdata_o <= 32'h0;
         cfg_rvalid_o <= 1'b0;
      end else begin
         cfg_rvalid_o <= cfg_rd_i;
         if (cfg_rd_i) begin
            unique case (cfg_addr_i)
               VC0_RESOURCE_STATUS_OFS: cfg_rdata_o <= status_word;
               VC1_RESOURCE_CAPABILITY_OFS: cfg_rdata_o <= cap_word;
               default: cfg_rdata_o <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Outputs to arbiter
   // ----------------------------------------
   // Scheme 0 (fixed round robin) does not use the table
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         arb_table_coherency_flag_o <= 1'b0;
         table_in_use_o <= 1'b0;
         arb_scheme_capability_o <= ARB_CAP_RESET;
         arb_table_offset_o <= TBL_OFS_RESET;
      end else begin
         arb_table_coherency_flag_o <= coherency_reg;
         table_in_use_o <= arb_scheme_select_i != 3'h0;
         arb_scheme_capability_o <= cap_reg;
         arb_table_offset_o <= ofs_reg;
      end
   end
endmodule

// ==== vc_res_checker_assertions.sv ====
// Assertion checker for the VC resource status and capability block
`timescale 1ns/1ps
module vc_res_checker (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic write_lock_i,
   input wire logic arb_table_wr_i,
   input wire logic [2:0] arb_scheme_select_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic arb_table_coherency_flag_o,
   input wire logic table_in_use_o,
   input wire logic arb_load_busy_o,
   input wire logic [7:0] arb_scheme_capability_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // ----
   // Properties
   // ----
   wire st = cfg_rd_i && cfg_addr_i == 12'h218;
   wire cp = cfg_rd_i && cfg_addr_i == 12'h21c;
   wire cw = cfg_wr_i && cfg_addr_i == 12'h214 && cfg_be_i[2] && !arb_load_busy_o;
   a_flag_on_write: assert property (
      arb_table_wr_i && !arb_load_busy_o |-> ##2 arb_table_coherency_flag_o)
      else $error("coherency flag not set");
   a_flag_held: assert property (
      $fell(arb_table_coherency_flag_o) |->
      $past(arb_load_busy_o, 3))
      else $error("coherency flag dropped without load");
   a_load_run: assert property (
      cw && cfg_wdata_i[16] |=> arb_load_busy_o[*4] ##1 !arb_load_busy_o)
      else $error("load length wrong");
   a_zero_no_load: assert property (
      cw && !cfg_wdata_i[16] |=> !arb_load_busy_o)
      else $error("load started by zero");
   a_status_zero: assert property (
      st |=> cfg_rdata_o[15:0] == 16'h0 && cfg_rdata_o[31:17] == 15'h0)
      else $error("status reserved or pending bit set");
   a_cap_fixed: assert property (
      cp |=> cfg_rdata_o[0] && cfg_rdata_o[5:1] == 5'h0 && cfg_rdata_o[23:8] == 16'h0)
      else $error("capability fixed bits wrong");
   a_lock_hold: assert property (
      cfg_wr_i && write_lock_i && cfg_addr_i == 12'h21c |=> ##1
      $stable(arb_scheme_capability_o)) else $error("locked write took");
   a_in_use: assert property (
      arb_scheme_select_i != 3'h0 |=> table_in_use_o)
      else $error("table use flag low");
endmodule
bind vc_resource_status_capability vc_res_checker u_chk (.*);

// ==== vc_resource_status_capability_tb_top.sv ====
// Self-checking testbench for the VC resource status and capability block
`timescale 1ns/1ps
module vc_resource_status_capability_tb_top import vc_res_pkg::*;;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic [11:0] cfg_addr_i = 12'h000;
   logic [31:0] cfg_wdata_i = 32'h0;
   logic [3:0] cfg_be_i = 4'h0;
   logic write_lock_i = 1'b0;
   logic arb_table_wr_i = 1'b0;
   logic [2:0] arb_scheme_select_i = 3'h0;
   logic [31:0] cfg_rdata_o;
   logic cfg_rvalid_o, arb_table_coherency_flag_o, table_in_use_o;
   logic arb_load_busy_o;
   logic [7:0] arb_scheme_capability_o, arb_table_offset_o;
   int n_fail = 0;
   int check_count = 0;
   vc_resource_status_capability u_dut (.*);
   always #2 core_clk_i = ~core_clk_i;
   // ----
   // Bus tasks
   // ----
   task automatic chk(input string nm, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] be);
      @(negedge core_clk_i);
      {cfg_wr_i, cfg_addr_i, cfg_wdata_i, cfg_be_i} = {1'b1, a, d, be};
      @(negedge core_clk_i);
      cfg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(negedge core_clk_i);
      {cfg_rd_i, cfg_addr_i} = {1'b1, a};
      @(negedge core_clk_i);
      cfg_rd_i = 1'b0;
      chk("rvalid", 32'h1, {31'h0, cfg_rvalid_o});
      chk("rdata", exp, cfg_rdata_o);
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic t_cap;
      rd(VC1_RESOURCE_CAPABILITY_OFS, 32'h1);
      wr(VC1_RESOURCE_CAPABILITY_OFS, 32'hffff_ffff, 4'hf);
      rd(VC1_RESOURCE_CAPABILITY_OFS, 32'hff00_00c1);
      chk("cap", 32'hc1, {24'h0, arb_scheme_capability_o});
      write_lock_i = 1'b1;
      wr(VC1_RESOURCE_CAPABILITY_OFS, 32'h0, 4'hf);
      rd(VC1_RESOURCE_CAPABILITY_OFS, 32'hff00_00c1);
      write_lock_i = 1'b0;
      wr(VC1_RESOURCE_CAPABILITY_OFS, 32'h1200_0000, 4'h9);
      rd(VC1_RESOURCE_CAPABILITY_OFS, 32'h1200_0001);
      chk("offset", 32'h12, {24'h0, arb_table_offset_o});
      $display("t_cap done");
   endtask
   task automatic t_coh;
      rd(VC0_RESOURCE_STATUS_OFS, 32'h0);
      chk("in_use0", 32'h0, {31'h0, table_in_use_o});
      @(negedge core_clk_i);
      arb_table_wr_i = 1'b1;
      @(negedge core_clk_i);
      arb_table_wr_i = 1'b0;
      rd(VC0_RESOURCE_STATUS_OFS, 32'h1_0000);
      chk("flag", 32'h1, {31'h0, arb_table_coherency_flag_o});
      wr(VC0_RESOURCE_CONTROL_OFS, 32'h0, 4'h4);
      rd(VC0_RESOURCE_STATUS_OFS, 32'h1_0000);
      wr(VC0_RESOURCE_CONTROL_OFS, 32'h1_0000, 4'h4);
      chk("busy", 32'h1, {31'h0, arb_load_busy_o});
      rd(VC0_RESOURCE_STATUS_OFS, 32'h1_0000);
      // Fixed wait: load length is set by LOAD_CYCLES
      repeat (LOAD_CYCLES) @(negedge core_clk_i);
      rd(VC0_RESOURCE_STATUS_OFS, 32'h0);
      chk("flag_clr", 32'h0, {31'h0, arb_table_coherency_flag_o});
      rd(VC0_RESOURCE_CONTROL_OFS, 32'h0);
      arb_scheme_select_i = 3'h1;
      repeat (2) @(negedge core_clk_i);
      chk("in_use", 32'h1, {31'h0, table_in_use_o});
      $display("t_coh done");
   endtask
   initial begin
      repeat (12) @(negedge core_clk_i);
      reset_i = 1'b0;
      t_cap();
      t_coh();
      summarize();
   end
   initial begin
      #2000;
      n_fail++;
      summarize();
   end
endmodule
